// ---- hw/dvl_cfg.svh ----
// named constants for the dynamic core voltage limit checker
// assumes a 50 MHz clock; voltages are held in quarter-millivolt units
`ifndef DVL_CFG_SVH
`define DVL_CFG_SVH
// ==========================================================
// timing
`define DVL_CLK_MHZ       50
`define DVL_CLK_PER       20
`define DVL_CONV_MS       100
`define DVL_WIN_US        1500
`define DVL_CONV_CYC      (`DVL_CONV_MS * 1000 * `DVL_CLK_MHZ)
`define DVL_WIN_CYC       (`DVL_WIN_US * `DVL_CLK_MHZ)
`define DVL_NSAMP         64
`define DVL_AVG_SHIFT     6
`define DVL_SKEW_DLY      400
`define DVL_SKEW_CYC      ((`DVL_SKEW_DLY + `DVL_CLK_PER - 1) / `DVL_CLK_PER)
// ==========================================================
// voltage scaling, quarter mV units
`define DVL_UPPER_CAP     15'h18CE
`define DVL_CORE_LSB      15'h0030
`define DVL_A_BASE        15'h1900
`define DVL_A_STEP        15'h0032
`define DVL_A_OFF         7'h3F
`define DVL_B_BASE        15'h1900
`define DVL_B_STEP        15'h0019
`define DVL_B_OFF         7'h7F
`define DVL_C_BASE        15'h1964
`define DVL_C_STEP        15'h0019
`define DVL_C_OFF         7'h00
// ==========================================================
// register map, byte offsets
`define DVL_OFF_CTRL      8'h00
`define DVL_OFF_UPOFF     8'h04
`define DVL_OFF_LOOFF     8'h08
`define DVL_OFF_STATLIM   8'h0C
`define DVL_OFF_ERR_BMC   8'h10
`define DVL_OFF_ERR_HOST  8'h14
`define DVL_OFF_AVG1      8'h18
`define DVL_OFF_AVG2      8'h1C
`define DVL_OFF_TEMP      8'h20
// ==========================================================
// fields and reset values
`define DVL_CTRL_EN       0
`define DVL_CTRL_MODE     1
`define DVL_CTRL_R11      3
`define DVL_CTRL_R15      4
`define DVL_ERR_GPI       4
`define DVL_AVG_SKIP      16
`define DVL_AVG_UPDIS     17
`define DVL_CTRL_RST      5'h00
`define DVL_OFF_RST       15'h00C8
`define DVL_STATLIM_RST   32'h00FF_00FF
`endif

// ---- hw/dvl_pkg.sv ----
// types for the dynamic core voltage limit checker
// assumes dvl_cfg.svh for all numeric constants
package dvl_pkg;
  // ==========================================================
  // regulator modes and sequencer states
  typedef enum logic [1:0] {
    DVL_MODE_A = 2'h0,
    DVL_MODE_B = 2'h1,
    DVL_MODE_C = 2'h2
  } dvl_mode_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_HOLD = 3'h1,
    ST_WIN  = 3'h3,
    ST_CMP  = 3'h2,
    ST_CHK  = 3'h6
  } dvl_state_e;
endpackage : dvl_pkg

// ---- hw/dvl_vid_chan.sv ----
// one identification channel: skew filter, code table, window average
// assumes window strobes from the sequencer in dvl_top
`timescale 1ns/10ps
`include "dvl_cfg.svh"
module dvl_vid_chan
  import dvl_pkg::*;
#(
  parameter int VW = 15
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire dvl_mode_e     mode,
  input  wire logic [5:0]    vid_lines,
  input  wire logic          vid_bit6,
  input  wire logic          win_start,
  input  wire logic          sample_tick,
  input  wire logic          win_end,
  output logic      [VW-1:0] avg_reg,
  output logic               skip_reg
);
  localparam int SKEW = `DVL_SKEW_CYC;
  localparam int SW   = VW + `DVL_AVG_SHIFT;
  logic [6:0]    vid_now;
  logic [6:0]    cand_reg;
  logic [6:0]    stable_reg;
  logic [7:0]    cnt_reg;
  logic [VW-1:0] volt;
  logic          is_off;
  logic [SW-1:0] sum_reg;
  logic          off_seen_reg;
  wire           same    = (vid_now == cand_reg);
  wire           settled = same && (cnt_reg == 8'(SKEW - 1));
  // ==========================================================
  // code width per mode; bit six only outside mode a
  assign vid_now = (mode == DVL_MODE_A) ? {1'b0, vid_lines} : {vid_bit6, vid_lines}; // [RULE3] [RULE15]
  // code table to nominal voltage
  always_comb begin // [RULE18]
    case (mode)
      DVL_MODE_A: begin
        is_off = (stable_reg == `DVL_A_OFF);
        volt   = `DVL_A_BASE - {8'h00, stable_reg} * `DVL_A_STEP;
      end
      DVL_MODE_B: begin
        is_off = (stable_reg == `DVL_B_OFF);
        volt   = `DVL_B_BASE - {8'h00, stable_reg} * `DVL_B_STEP;
      end
      default: begin
        is_off = (stable_reg == `DVL_C_OFF);
        volt   = `DVL_C_BASE - {8'h00, stable_reg} * `DVL_C_STEP;
      end
    endcase
  end
  // ==========================================================
  // skew filter: a code counts only once stable long enough
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cand_reg   <= 7'h00;
      cnt_reg    <= 8'h00;
      stable_reg <= 7'h00;
    end else begin
      cand_reg <= vid_now;
      cnt_reg  <= (!same || settled) ? 8'h00 : cnt_reg + 8'h01; // [RULE6]
      if (settled) begin
        stable_reg <= cand_reg; // [RULE6]
      end
    end
  end
  // window accumulation and averaged result
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sum_reg      <= '0;
      off_seen_reg <= 1'b0;
      avg_reg      <= '0;
      skip_reg     <= 1'b0;
    end else begin
      if (win_start) begin
        sum_reg      <= '0;
        off_seen_reg <= 1'b0;
      end else if (sample_tick) begin
        sum_reg      <= sum_reg + {{`DVL_AVG_SHIFT{1'b0}}, volt}; // [RULE7]
        off_seen_reg <= off_seen_reg | is_off; // [RULE12]
      end
      if (win_end) begin
        avg_reg  <= sum_reg[SW-1:`DVL_AVG_SHIFT]; // [RULE7]
        skip_reg <= off_seen_reg; // [RULE12]
      end
    end
  end
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_skew_filter: assert property ($changed(stable_reg) |-> $past(cnt_reg) == 8'(SKEW - 1)) // [RULE6]
    else $error("code accepted before settling");
  a_off_skip: assert property (win_end && (off_seen_reg || (sample_tick && is_off)) |=> skip_reg) // [RULE12]
    else $error("off code in window not flagged");
endmodule : dvl_vid_chan

// ---- hw/dvl_top.sv ----
// dynamic core voltage limit checker with APB register slave
// assumes synchronous converter results and identification inputs
// Overview of operation
// (RULE1) one identification channel per processor
// (RULE2) static limit checks run beside dynamic
// (RULE3) three selectable modes set code meaning
// (RULE4) processor steps code slowly in mode a
// (RULE5) code changes at most every 5 us
// (RULE6) skew glitches on code lines filtered
// (RULE7) compare against window average, not instant
// (RULE8) averaging window lasts 1.5 ms
// (RULE9) limits are average plus/minus offsets
// (RULE10) outside limits raises channel error event
// (RULE11) all comparisons run every 100 ms
// (RULE12) off code in window skips check
// (RULE13) software sizes offsets for accuracy
// (RULE14) upper check dropped above 1.5875 V
// (RULE15) mode a: bit-six pins are inputs
// (RULE16) inputs eleven, fifteen routed to fans
// (RULE17) routed temperature value has msb inverted
// (RULE18) codes translated via mode table first
`timescale 1ns/10ps
`include "dvl_cfg.svh"
module dvl_top
  import dvl_pkg::*;
#(
  parameter int CONV_CYC = `DVL_CONV_CYC,
  parameter int WIN_CYC  = `DVL_WIN_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [5:0]  cpu_one_voltage_id_lines,
  input  wire logic [5:0]  cpu_two_voltage_id_lines,
  input  wire logic        cpu_one_seventh_voltage_id_bit,
  input  wire logic        cpu_two_seventh_voltage_id_bit,
  input  wire logic [7:0]  cpu_one_core_voltage_input,
  input  wire logic [7:0]  cpu_two_core_voltage_input,
  input  wire logic [7:0]  analog_input_eleven,
  input  wire logic [7:0]  analog_input_fifteen,
  output logic      [7:0]  fan_temp_eleven,
  output logic      [7:0]  fan_temp_fifteen,
  output logic      [1:0]  dyn_err_evt,
  output logic      [1:0]  static_err_evt
);
  localparam int VW       = 15;
  localparam int SUB      = WIN_CYC / `DVL_NSAMP;
  localparam int HOLD_CYC = CONV_CYC - WIN_CYC - 2; // window keeps its full length
  // ==========================================================
  // register state
  logic [4:0]    ctrl_reg;
  logic [VW-1:0] up_off_reg;
  logic [VW-1:0] lo_off_reg;
  logic [31:0]   statlim_reg;
  logic [3:0]    err_bmc_reg;
  logic [3:0]    err_host_reg;
  logic [1:0]    updis_reg;
  logic [31:0]   prdata_reg;
  dvl_state_e    state_reg;
  dvl_state_e    state_next;
  logic [31:0]   cnt_reg;
  logic [31:0]   cnt_next;
  logic [15:0]   sub_reg;
  logic [7:0]    t11_reg;
  logic [7:0]    t15_reg;
  logic [1:0]    dyn_evt_reg;
  logic [1:0]    st_evt_reg;
  // ==========================================================
  // APB decode
  wire [7:0] addr     = paddr[7:0];
  wire       hi_zero  = (paddr[31:8] == 24'h00_0000);
  wire       hit_ctrl = hi_zero && (addr == `DVL_OFF_CTRL);
  wire       hit_up   = hi_zero && (addr == `DVL_OFF_UPOFF);
  wire       hit_lo   = hi_zero && (addr == `DVL_OFF_LOOFF);
  wire       hit_sl   = hi_zero && (addr == `DVL_OFF_STATLIM);
  wire       hit_eb   = hi_zero && (addr == `DVL_OFF_ERR_BMC);
  wire       hit_eh   = hi_zero && (addr == `DVL_OFF_ERR_HOST);
  wire       hit_a1   = hi_zero && (addr == `DVL_OFF_AVG1);
  wire       hit_a2   = hi_zero && (addr == `DVL_OFF_AVG2);
  wire       hit_tp   = hi_zero && (addr == `DVL_OFF_TEMP);
  wire       mapped   = hit_ctrl | hit_up | hit_lo | hit_sl | hit_eb | hit_eh
                      | hit_a1 | hit_a2 | hit_tp;
  wire       setup    = psel && !penable;
  wire       wr       = psel && penable && pwrite && mapped;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_reg;
  // ==========================================================
  // control fields
  wire       en      = ctrl_reg[`DVL_CTRL_EN];
  wire [1:0] mode_f  = ctrl_reg[`DVL_CTRL_MODE +: 2];
  wire       r11     = ctrl_reg[`DVL_CTRL_R11];
  wire       r15     = ctrl_reg[`DVL_CTRL_R15];
  dvl_mode_e mode;
  assign mode = (mode_f == 2'h0) ? DVL_MODE_A : (mode_f == 2'h1) ? DVL_MODE_B : DVL_MODE_C; // [RULE3]
  // bit-six pins read back as inputs in mode a
  wire [1:0] gpi = (mode == DVL_MODE_A) ?
                   {cpu_two_seventh_voltage_id_bit, cpu_one_seventh_voltage_id_bit} : 2'h0; // [RULE15]
  // ==========================================================
  // conversion-cycle sequencer: hold, window, capture, check
  wire win_start   = (state_reg == ST_HOLD) && (cnt_reg == 32'(HOLD_CYC - 1));
  wire sample_tick = (state_reg == ST_WIN) && (sub_reg == 16'(SUB - 1)); // [RULE8]
  wire win_end     = (state_reg == ST_CMP);
  wire chk         = (state_reg == ST_CHK); // [RULE11]
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 32'h0000_0001;
    case (state_reg)
      ST_IDLE: begin
        cnt_next = 32'h0000_0000;
        if (en) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (win_start) begin
          state_next = ST_WIN;
          cnt_next   = 32'h0000_0000;
        end
      end
      ST_WIN: begin
        if (cnt_reg == 32'(WIN_CYC - 1)) begin // [RULE8]
          state_next = ST_CMP;
          cnt_next   = 32'h0000_0000;
        end
      end
      ST_CMP: state_next = ST_CHK;
      ST_CHK: begin
        state_next = ST_HOLD;
        cnt_next   = 32'h0000_0000;
      end
      default: begin
        state_next = ST_IDLE;
        cnt_next   = 32'h0000_0000;
      end
    endcase
    if (!en) begin
      state_next = ST_IDLE;
      cnt_next   = 32'h0000_0000;
    end
  end
  // sequencer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 32'h0000_0000;
      sub_reg   <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      sub_reg   <= (win_start || sample_tick) ? 16'h0000 : sub_reg + 16'h0001;
    end
  end
  // ==========================================================
  // per-processor channels and comparisons
  wire [5:0]    vid_l [2];
  wire          vid_6 [2];
  wire [7:0]    rd    [2];
  wire [VW-1:0] avg   [2];
  wire          skip  [2];
  wire [1:0]    dyn_hit;
  wire [1:0]    st_hit;
  wire [1:0]    updis;
  assign vid_l[0] = cpu_one_voltage_id_lines;
  assign vid_l[1] = cpu_two_voltage_id_lines;
  assign vid_6[0] = cpu_one_seventh_voltage_id_bit;
  assign vid_6[1] = cpu_two_seventh_voltage_id_bit;
  assign rd[0]    = cpu_one_core_voltage_input;
  assign rd[1]    = cpu_two_core_voltage_input;
  for (genvar i = 0; i < 2; i++) begin : g_ch
    wire [VW-1:0] rv     = {7'h00, rd[i]} * `DVL_CORE_LSB;
    wire [VW:0]   up_lim = {1'b0, avg[i]} + {1'b0, up_off_reg}; // [RULE9]
    wire [VW:0]   lo_sum = {1'b0, rv} + {1'b0, lo_off_reg}; // [RULE9]
    wire          no_up  = up_lim > {1'b0, `DVL_UPPER_CAP}; // [RULE14]
    wire          hi_err = !no_up && ({1'b0, rv} > up_lim); // [RULE10]
    wire          lo_err = lo_sum < {1'b0, avg[i]}; // [RULE10]
    wire [7:0]    s_hi   = statlim_reg[16*i +: 8];
    wire [7:0]    s_lo   = statlim_reg[16*i+8 +: 8];
    assign updis[i]   = no_up;
    assign dyn_hit[i] = chk && !skip[i] && (hi_err || lo_err); // [RULE1] [RULE12]
    assign st_hit[i]  = chk && ((rd[i] > s_hi) || (rd[i] < s_lo)); // [RULE2]
    dvl_vid_chan #(
      .VW (VW)
    ) u_chan (
      .clk         (clk),
      .rst_n       (rst_n),
      .mode        (mode),
      .vid_lines   (vid_l[i]),
      .vid_bit6    (vid_6[i]),
      .win_start   (win_start),
      .sample_tick (sample_tick),
      .win_end     (win_end),
      .avg_reg     (avg[i]),
      .skip_reg    (skip[i])
    );
  end
  // ==========================================================
  // sticky error status; a set beats a same-cycle clear
  wire [3:0] err_set = {st_hit, dyn_hit};
  wire [3:0] clr_b   = (wr && hit_eb) ? pwdata[3:0] : 4'h0;
  wire [3:0] clr_h   = (wr && hit_eh) ? pwdata[3:0] : 4'h0;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_bmc_reg  <= 4'h0;
      err_host_reg <= 4'h0;
      updis_reg    <= 2'h0;
      dyn_evt_reg  <= 2'h0;
      st_evt_reg   <= 2'h0;
    end else begin
      err_bmc_reg  <= (err_bmc_reg & ~clr_b) | err_set; // [RULE10]
      err_host_reg <= (err_host_reg & ~clr_h) | err_set; // [RULE10]
      dyn_evt_reg  <= dyn_hit; // [RULE10]
      st_evt_reg   <= st_hit; // [RULE2]
      if (chk) begin
        updis_reg <= updis; // [RULE14]
      end
    end
  end
  assign dyn_err_evt    = dyn_evt_reg;
  assign static_err_evt = st_evt_reg;
  // ==========================================================
  // software-written configuration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg    <= `DVL_CTRL_RST;
      up_off_reg  <= `DVL_OFF_RST;
      lo_off_reg  <= `DVL_OFF_RST;
      statlim_reg <= `DVL_STATLIM_RST;
    end else if (wr) begin
      if (hit_ctrl) ctrl_reg    <= pwdata[4:0];
      if (hit_up)   up_off_reg  <= pwdata[VW-1:0]; // [RULE9]
      if (hit_lo)   lo_off_reg  <= pwdata[VW-1:0]; // [RULE9]
      if (hit_sl)   statlim_reg <= pwdata;
    end
  end
  // ==========================================================
  // read mux, captured during the setup cycle
  wire [31:0] err_rd_b = {26'h000_0000, gpi, err_bmc_reg}; // [RULE15]
  wire [31:0] err_rd_h = {26'h000_0000, gpi, err_host_reg}; // [RULE15]
  wire [31:0] avg_rd1  = {14'h0000, updis_reg[0], skip[0], 1'b0, avg[0]};
  wire [31:0] avg_rd2  = {14'h0000, updis_reg[1], skip[1], 1'b0, avg[1]};
  wire [31:0] rd_mux   = hit_ctrl ? {27'h000_0000, ctrl_reg} :
                         hit_up   ? {17'h0_0000, up_off_reg} :
                         hit_lo   ? {17'h0_0000, lo_off_reg} :
                         hit_sl   ? statlim_reg :
                         hit_eb   ? err_rd_b :
                         hit_eh   ? err_rd_h :
                         hit_a1   ? avg_rd1 :
                         hit_a2   ? avg_rd2 :
                         hit_tp   ? {16'h0000, t15_reg, t11_reg} : 32'h0000_0000;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end
  // ==========================================================
  // temperature routing to fan control, signed by msb inversion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t11_reg <= 8'h00;
      t15_reg <= 8'h00;
    end else begin
      t11_reg <= r11 ? {~analog_input_eleven[7], analog_input_eleven[6:0]} : 8'h00; // [RULE16] [RULE17]
      t15_reg <= r15 ? {~analog_input_fifteen[7], analog_input_fifteen[6:0]} : 8'h00; // [RULE16] [RULE17]
    end
  end
  assign fan_temp_eleven  = t11_reg;
  assign fan_temp_fifteen = t15_reg;
  // ==========================================================
  // checks: cycle-period helper and properties
  logic [31:0] per_reg;
  logic        seen_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_reg  <= 32'h0000_0000;
      seen_reg <= 1'b0;
    end else begin
      per_reg  <= chk ? 32'h0000_0000 : per_reg + 32'h0000_0001;
      seen_reg <= chk | (seen_reg & en);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_check_period: assert property (chk && seen_reg |-> per_reg == 32'(CONV_CYC - 1)) // [RULE11]
    else $error("check spacing wrong");
  a_evt_at_check: assert property (dyn_err_evt[0] |-> $past(chk) && !$past(skip[0])) // [RULE12]
    else $error("dynamic event outside check or while skipped");
  a_high_error: assert property (chk && !skip[0] && !updis[0] && g_ch[0].hi_err |=> dyn_err_evt[0]) // [RULE10]
    else $error("high reading missed");
  a_low_error: assert property (chk && !skip[1] && g_ch[1].lo_err |=> dyn_err_evt[1]) // [RULE10]
    else $error("low reading missed");
  a_upper_cap: assert property (chk && updis[0] && !g_ch[0].lo_err |=> !dyn_err_evt[0]) // [RULE14]
    else $error("upper check not disabled above cap");
  a_status_sticky: assert property (dyn_err_evt[1] |-> err_bmc_reg[1] && err_host_reg[1]) // [RULE10]
    else $error("event not held in status");
  a_static_cmp: assert property (chk && (rd[0] > statlim_reg[7:0]) |=> static_err_evt[0]) // [RULE2]
    else $error("static high missed");
  a_temp_sign: assert property ($past(r11) |-> fan_temp_eleven == {~$past(analog_input_eleven[7]), $past(analog_input_eleven[6:0])}) // [RULE17]
    else $error("temperature sign not inverted");
  a_gpi_mode: assert property (mode != DVL_MODE_A |-> gpi == 2'h0) // [RULE15]
    else $error("gpi shown outside mode a");
  c_dyn_err:  cover property (dyn_err_evt[0]);
  c_skipped:  cover property (chk && skip[0]);
  c_up_dis:   cover property (chk && updis[0]);
  c_stat_err: cover property (static_err_evt[1]);
endmodule : dvl_top

// ---- tb/dvl_vid_proc_model.sv ----
// processor model driving one set of identification lines
// assumes a 50 MHz clock; target, off request and glitch come from the bench
`timescale 1ns/10ps
module dvl_vid_proc_model #(
  parameter int HOLD = 250
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [6:0] target,
  input  wire logic       off_req,
  input  wire logic [6:0] off_code,
  input  wire logic       glitch,
  output logic      [5:0] vid_lines,
  output logic            vid_bit6
);
  logic [5:0] cur_reg;
  logic [5:0] old_reg;
  logic [8:0] hold_reg;
  logic [1:0] skew_reg;
  logic [1:0] glt_reg;
  wire        show_off = off_req | (glt_reg != 2'h0);
  // one lsb step toward target, steps spaced by hold cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {cur_reg, old_reg, hold_reg, skew_reg, glt_reg} <= '0;
    end else begin
      glt_reg  <= glitch ? 2'h3 : glt_reg - 2'(glt_reg != 2'h0);
      skew_reg <= skew_reg - 2'(skew_reg != 2'h0);
      if (hold_reg != 9'h000) begin
        hold_reg <= hold_reg - 9'h001;
      end else if (cur_reg != target[5:0]) begin
        old_reg  <= cur_reg;
        cur_reg  <= (cur_reg < target[5:0]) ? cur_reg + 6'h01 : cur_reg - 6'h01;
        hold_reg <= 9'(HOLD - 1);
        skew_reg <= 2'h2;
      end
    end
  end
  // lsb lags the other lines after a step; off request or glitch shows off code
  assign vid_lines = show_off ? off_code[5:0] :
                     (skew_reg != 2'h0) ? {cur_reg[5:1], old_reg[0]} : cur_reg;
  assign vid_bit6  = show_off ? off_code[6] : target[6];
endmodule : dvl_vid_proc_model

// ---- tb/tb_top.sv ----
// self-checking bench for the dynamic core voltage limit checker
// assumes shortened period and window parameters and zero-wait apb
`timescale 1ns/10ps
module tb_top;
  import dvl_pkg::*;
  localparam int CONV = 2000;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, e, off1 = 0, gl2 = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, q, sl, rv[4];
  logic        pready, pslverr, b1, b2;
  logic [6:0]  tg1 = 0, tg2 = 0, offc = 7'h3f;
  logic [5:0]  v1, v2;
  logic [7:0]  r1 = 0, r2 = 0, a11 = 0, a15 = 0, f11, f15, p11, p15;
  logic [1:0]  dyn, sta, ev, sv;
  int          n_errors = 0, compares = 0, cyc = 0;
  // design under test and two processor models
  dvl_top #(.CONV_CYC(CONV), .WIN_CYC(640)) dvl_top_inst (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_one_voltage_id_lines(v1),
    .cpu_two_voltage_id_lines(v2), .cpu_one_seventh_voltage_id_bit(b1),
    .cpu_two_seventh_voltage_id_bit(b2), .cpu_one_core_voltage_input(r1),
    .cpu_two_core_voltage_input(r2), .analog_input_eleven(a11), .analog_input_fifteen(a15),
    .fan_temp_eleven(f11), .fan_temp_fifteen(f15), .dyn_err_evt(dyn), .static_err_evt(sta));
  dvl_vid_proc_model proc_one (.clk(clk), .rst_n(rst_n), .target(tg1), .off_req(off1),
    .off_code(offc), .glitch(1'b0), .vid_lines(v1), .vid_bit6(b1));
  dvl_vid_proc_model proc_two (.clk(clk), .rst_n(rst_n), .target(tg2), .off_req(1'b0),
    .off_code(offc), .glitch(gl2), .vid_lines(v2), .vid_bit6(b2));
  always #10 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 40000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic final_report;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // one apb transfer: setup, access until pready, then release
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  // nominal quarter-mV voltage of a code in each mode
  function automatic int volt(input logic [1:0] m, input logic [6:0] c);
    if (m == 2'h0) return 6400 - 50 * c[5:0];
    return (m == 2'h1) ? 6400 - 25 * c : 6500 - 25 * c;
  endfunction : volt
  function automatic logic derr(input int av, input logic [7:0] r, input int up, input int lo);
    return ((av + up <= 6350) && r * 48 > av + up) || (r * 48 + lo < av);
  endfunction : derr
  function automatic logic [7:0] rr;
    return 8'(120 + $urandom % 21);
  endfunction : rr
  // one check period (two when offon is 0) with fixed codes, readings and random offsets and routing
  task automatic run(input logic [1:0] m, input logic [6:0] c1, input logic [6:0] c2,
                     input logic [7:0] x1, input logic [7:0] x2, input logic offon);
    int up, lo, av1, av2;
    logic [31:0] ctl;
    logic [1:0] ed, es;
    up = 100 + $urandom % 200;
    lo = 100 + $urandom % 200;
    tg1 <= c1; tg2 <= c2; r1 <= x1; r2 <= x2;
    offc <= (m == 2'h0) ? 7'h3f : (m == 2'h1) ? 7'h7f : 7'h00;
    apb(1, 32'h0000_0004, up);
    apb(1, 32'h0000_0008, lo);
    apb(1, 32'h0000_0010, 32'h0000_000f);
    apb(1, 32'h0000_0014, 32'h0000_000f);
    repeat (1700) @(posedge clk);
    ctl = {27'h0, 2'($urandom), m, 1'b1};
    apb(1, 32'h0000_0000, ctl);
    ev = 0; sv = 0;
    for (int i = 0; i < (offon ? CONV : 2 * CONV) + 10; i++) begin
      @(posedge clk);
      p11 = a11; p15 = a15;
      a11 <= 8'($urandom); a15 <= 8'($urandom);
      off1 <= offon && i >= 1500 && i < 1600;
      gl2 <= offon && i == 1550;
      #1;
      if (i > 0) chk("temp eleven", ctl[3] ? {~p11[7], p11[6:0]} : 0, f11);
      if (i > 0) chk("temp fifteen", ctl[4] ? {~p15[7], p15[6:0]} : 0, f15);
      ev |= dyn; sv |= sta;
    end
    apb(1, 32'h0000_0000, {ctl[31:1], 1'b0});
    av1 = volt(m, c1); av2 = volt(m, c2);
    ed = {derr(av2, x2, up, lo), derr(av1, x1, up, lo) & ~offon};
    es = {x2 > sl[23:16] || x2 < sl[31:24], x1 > sl[7:0] || x1 < sl[15:8]};
    chk("dynamic events", ed, ev);
    chk("static events", es, sv);
    apb(0, 32'h0000_0018, 0);
    if (offon) chk("skip one", 1, q[16]);
    else chk("average one", {av1 + up > 6350, 2'b00, 15'(av1)}, q[17:0]);
    apb(0, 32'h0000_001c, 0);
    chk("average two", {av2 + up > 6350, 2'b00, 15'(av2)}, q[17:0]);
    for (int k = 0; k < 2; k++) begin
      apb(0, 32'(16 + 4 * k), 0);
      chk("error status", {(m == 2'h0) ? {c2[6], c1[6]} : 2'h0, es, ed}, q[5:0]);
    end
  endtask : run
  initial begin
    void'($urandom(89999));
    rv = '{32'h0, 32'h0000_00c8, 32'h0000_00c8, 32'h00ff_00ff};
    sl = rv[3];
    repeat (20) @(posedge clk);
    rst_n <= 1;
    for (int k = 0; k < 4; k++) begin
      apb(0, 32'(4 * k), 0);
      chk("reset value", rv[k], q);
    end
    apb(0, 32'h0000_0100, 0);
    chk("unmapped error", 1, e);
    chk("unmapped data", 0, q);
    run(2'h0, 7'h40, 7'h00, 8'hff, rr(), 0);
    sl = 32'h7c88_7c88;
    apb(1, 32'h0000_000c, sl);
    run(2'h0, 7'h04, 7'h06, rr(), rr(), 0);
    run(2'h1, 7'h08, 7'h0a, rr(), rr(), 0);
    run(2'h2, 7'h0c, 7'h0e, rr(), rr(), 0);
    run(2'h2, 7'h0c, 7'h0e, 8'h00, rr(), 1);
    final_report();
  end
endmodule : tb_top
